/* File: core/cmt_defines.svh */
// Register commands, field positions, reset values and timing constants.
`ifndef CMT_DEFINES_SVH
`define CMT_DEFINES_SVH
`define CMT_DIR_BIT 7
`define CMT_CMD_MON_LOW 7'h0B
`define CMT_CMD_MON_HIGH 7'h0C
`define CMT_CMD_RECOG 7'h0D
`define CMT_CMD_RECOG_BRK 7'h0E
`define CMT_CMD_END_DET 7'h0F
`define CMT_CMD_END_BRK 7'h10
`define CMT_CMD_IRQ_MASK 7'h11
`define CMT_RST_RECOG 8'h13
`define CMT_RST_RECOG_BRK 8'h19
`define CMT_RST_END_DET 8'h40
`define CMT_RST_END_BRK 8'h64
`define CMT_RST_IRQ_MASK 5'h1F
`define CMT_MASK_GK 4
`define CMT_MASK_HK 3
`define CMT_MASK_OVERHEAT_STATUS 2
`define CMT_MASK_RAMP 1
`define CMT_MASK_GKP 0
`define CMT_RECOG_STEP_MS 16
`define CMT_BREAK_STEP_MS 4
`define CMT_END_STEP_MS 4
`define CMT_END_BRK_STEP_MS 1
`endif

/* File: core/cmt_pkg.sv */
// Types shared by the channel monitor and tone timing register bank.
package cmt_pkg;
    typedef logic [7:0] cmt_byte_t;
    typedef logic [6:0] cmt_cmd_t;
endpackage : cmt_pkg

/* File: core/cmt_regs.sv */
// Channel monitor, tone timing and line event mask register bank.
`timescale 1ns/10ps
`include "cmt_defines.svh"
module cmt_regs (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [7:0] wr_data,
    input wire logic microprocessor_port_mode,
    input wire logic compressed_mode,
    input wire logic tx_sample_valid,
    input wire logic [15:0] tx_sample,
    input wire logic [3:0] ground_key_status,
    input wire logic [3:0] off_hook_status,
    input wire logic overheat_status,
    input wire logic ramp_done_status,
    input wire logic ground_key_polarity_status,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic cmd_error,
    output logic [7:0] recognition_time_field,
    output logic [7:0] recognition_break_field,
    output logic [7:0] end_detect_field,
    output logic [7:0] end_break_field,
    output logic [4:0] line_event_irq_mask,
    output logic line_event_irq
);
    cmt_pkg::cmt_byte_t mon_low, next_mon_low;
    cmt_pkg::cmt_byte_t mon_high, next_mon_high;
    cmt_pkg::cmt_byte_t next_recog, next_recog_brk;
    cmt_pkg::cmt_byte_t next_end_det, next_end_brk;
    logic [4:0] next_mask;
    cmt_pkg::cmt_byte_t next_rd_data;
    logic next_rd_valid, next_cmd_error, next_irq;
    logic [3:0] gk_q, hk_q;
    logic ot_q, ramp_q, gkp_q;
    logic is_read;
    cmt_pkg::cmt_cmd_t cmd;

    // Read and write commands share the low seven bits of the code.
    function automatic logic known_cmd(input cmt_pkg::cmt_cmd_t c);
        return c >= `CMT_CMD_MON_LOW && c <= `CMT_CMD_IRQ_MASK;
    endfunction : known_cmd

    always_comb begin
        cmd = cmd_byte[6:0];
        is_read = ~cmd_byte[`CMT_DIR_BIT];
        next_mon_low = mon_low;
        next_mon_high = mon_high;
        // One capture per sample loads both bytes together; compressed mode takes the low byte and zeroes the high byte.
        if (tx_sample_valid) begin
            if (compressed_mode) begin
                next_mon_low = tx_sample[7:0];
                next_mon_high = 8'h00;
            end else begin
                next_mon_low = tx_sample[7:0];
                next_mon_high = tx_sample[15:8];
            end
        end
        next_recog = recognition_time_field;
        next_recog_brk = recognition_break_field;
        next_end_det = end_detect_field;
        next_end_brk = end_break_field;
        next_mask = line_event_irq_mask;
        next_rd_data = 8'h00;
        next_rd_valid = 1'b0;
        next_cmd_error = 1'b0;
        if (cmd_valid) begin
            if (!known_cmd(cmd)) begin
                next_cmd_error = 1'b1;
            end else if (is_read) begin
                next_rd_valid = 1'b1;
                unique case (cmd)
                    `CMT_CMD_MON_LOW: begin
                        next_rd_data = mon_low;
                        next_cmd_error = ~microprocessor_port_mode;
                    end
                    `CMT_CMD_MON_HIGH: begin
                        next_rd_data = compressed_mode ? 8'h00 : mon_high;
                        next_cmd_error = ~microprocessor_port_mode;
                    end
                    `CMT_CMD_RECOG: next_rd_data = recognition_time_field;
                    `CMT_CMD_RECOG_BRK: next_rd_data = recognition_break_field;
                    `CMT_CMD_END_DET: next_rd_data = end_detect_field;
                    `CMT_CMD_END_BRK: next_rd_data = end_break_field;
                    default: next_rd_data = {3'h0, line_event_irq_mask};
                endcase
            end else begin
                unique case (cmd)
                    `CMT_CMD_RECOG: next_recog = wr_data;
                    `CMT_CMD_RECOG_BRK: next_recog_brk = wr_data;
                    `CMT_CMD_END_DET: next_end_det = wr_data;
                    `CMT_CMD_END_BRK: next_end_brk = wr_data;
                    `CMT_CMD_IRQ_MASK: next_mask = wr_data[4:0];
                    default: next_cmd_error = 1'b1;
                endcase
            end
        end
        next_irq =
            (|(ground_key_status ^ gk_q) & ~line_event_irq_mask[`CMT_MASK_GK])
            | (|(off_hook_status ^ hk_q) & ~line_event_irq_mask[`CMT_MASK_HK])
            | (overheat_status & ~ot_q & ~line_event_irq_mask[`CMT_MASK_OVERHEAT_STATUS])
            | (ramp_done_status & ~ramp_q
               & ~line_event_irq_mask[`CMT_MASK_RAMP])
            | ((ground_key_polarity_status ^ gkp_q)
               & ~line_event_irq_mask[`CMT_MASK_GKP]);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mon_low <= 8'h00;
            mon_high <= 8'h00;
            recognition_time_field <= `CMT_RST_RECOG;
            recognition_break_field <= `CMT_RST_RECOG_BRK;
            end_detect_field <= `CMT_RST_END_DET;
            end_break_field <= `CMT_RST_END_BRK;
            line_event_irq_mask <= `CMT_RST_IRQ_MASK;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            cmd_error <= 1'b0;
            line_event_irq <= 1'b0;
            gk_q <= 4'h0;
            hk_q <= 4'h0;
            ot_q <= 1'b0;
            ramp_q <= 1'b0;
            gkp_q <= 1'b0;
        end else begin
            mon_low <= next_mon_low;
            mon_high <= next_mon_high;
            recognition_time_field <= next_recog;
            recognition_break_field <= next_recog_brk;
            end_detect_field <= next_end_det;
            end_break_field <= next_end_brk;
            line_event_irq_mask <= next_mask;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
            cmd_error <= next_cmd_error;
            line_event_irq <= next_irq;
            gk_q <= ground_key_status;
            hk_q <= off_hook_status;
            ot_q <= overheat_status;
            ramp_q <= ramp_done_status;
            gkp_q <= ground_key_polarity_status;
        end
    end
endmodule : cmt_regs

/* File: testbench/cmt_host_model.sv */
// Master processor model that issues command bytes.
`timescale 1ns/10ps
module cmt_host_model (
    input wire logic clk_sys,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic [7:0] wr_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        wr_data = 8'h00;
    end
    // Released lines show the inverse of their last value.
    task xfer(input logic [7:0] cmd, input logic [7:0] dat);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_byte <= cmd;
        wr_data <= dat;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_byte <= ~cmd;
        wr_data <= ~dat;
        #1;
    endtask : xfer
endmodule : cmt_host_model

/* File: testbench/cmt_regs_monitor.sv */
// Concurrent checks on the register bank ports.
`timescale 1ns/10ps
module cmt_regs_monitor (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [7:0] wr_data,
    input wire logic tx_sample_valid,
    input wire logic [15:0] tx_sample,
    input wire logic overheat_status,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic cmd_error,
    input wire logic [7:0] recognition_time_field,
    input wire logic [4:0] line_event_irq_mask,
    input wire logic line_event_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_sample_then_low;
        tx_sample_valid ##1 !tx_sample_valid ##1 cmd_valid && cmd_byte == 8'h0B;
    endsequence
    a_read_recog: assert property (cmd_valid && cmd_byte == 8'h0D |=>
        rd_valid && rd_data == $past(recognition_time_field)) else $error("bad");
    a_write_recog: assert property (cmd_valid && cmd_byte == 8'h8D |=>
        recognition_time_field == $past(wr_data)) else $error("bad");
    a_mask_write: assert property (cmd_valid && cmd_byte == 8'h91 |=>
        line_event_irq_mask == $past(wr_data[4:0])) else $error("bad");
    a_mask_reserved: assert property (cmd_valid && cmd_byte == 8'h11
        |=> rd_data[7:5] == 3'h0) else $error("bad");
    a_ro_write: assert property (cmd_valid && cmd_byte[7:1] == 7'h45
        |=> cmd_error) else $error("bad");
    a_overheat_rise: assert property (!line_event_irq_mask[2] &&
        $rose(overheat_status) |=> line_event_irq) else $error("bad");
    a_masked_quiet: assert property (line_event_irq_mask == 5'h1F
        |=> !line_event_irq) else $error("bad");
    a_monitor_low: assert property (s_sample_then_low |=>
        rd_data == $past(tx_sample[7:0], 3)) else $error("bad");
endmodule : cmt_regs_monitor
bind cmt_regs cmt_regs_monitor cmt_regs_monitor_inst (.*);

/* File: testbench/cmt_regs_tb_top.sv */
// Self-checking bench for the register bank.
`timescale 1ns/10ps
module cmt_regs_tb_top;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic microprocessor_port_mode = 1'b1;
    logic compressed_mode = 1'b0;
    logic tx_sample_valid = 1'b0;
    logic [15:0] tx_sample = 16'h0000;
    logic [10:0] st = 11'h000;
    logic cmd_valid, rd_valid, cmd_error, line_event_irq;
    logic [7:0] cmd_byte, wr_data, rd_data;
    logic [7:0] wv[5] = '{8'hFA, 8'hFA, 8'h00, 8'hFF, 8'hEA};
    logic [10:0] sv[10] = '{11'h004, 11'h000, 11'h002, 11'h000, 11'h001,
        11'h000, 11'h080, 11'h000, 11'h008, 11'h000};
    logic [9:0] sx = 10'b1010111111;
    int error_cnt = 0;
    int compares = 0;
    cmt_host_model cmt_host_model_inst (.*);
    cmt_regs cmt_regs_inst (.*, .ground_key_status(st[10:7]),
        .off_hook_status(st[6:3]), .overheat_status(st[2]),
        .ramp_done_status(st[1]), .ground_key_polarity_status(st[0]),
        .recognition_time_field(), .recognition_break_field(),
        .end_detect_field(), .end_break_field(), .line_event_irq_mask());
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [7:0] a, input logic [7:0] e);
        cmt_host_model_inst.xfer(a, 8'h00);
        chk(rd_data, e);
    endtask : rd
    task smp(input logic cm, input logic [15:0] v);
        @(posedge clk_sys);
        compressed_mode <= cm;
        tx_sample <= v;
        tx_sample_valid <= 1'b1;
        @(posedge clk_sys);
        tx_sample_valid <= 1'b0;
    endtask : smp
    task ev(input logic [10:0] v, input logic e);
        @(posedge clk_sys);
        st <= v;
        @(posedge clk_sys);
        #1;
        chk({7'h00, line_event_irq}, {7'h00, e});
    endtask : ev
    task conclude;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(8'h0D, 8'h13);
        rd(8'h0E, 8'h19);
        rd(8'h0F, 8'h40);
        rd(8'h10, 8'h64);
        rd(8'h11, 8'h1F);
        $display("defaults test done");
        for (int i = 0; i < 5; i++) begin
            cmt_host_model_inst.xfer(8'h8D + i[7:0], wv[i]);
            rd(8'h0D + i[7:0], wv[i] & ((i == 4) ? 8'h1F : 8'hFF));
        end
        $display("write test done");
        smp(1'b0, 16'h1234);
        rd(8'h0B, 8'h34);
        rd(8'h0C, 8'h12);
        smp(1'b1, 16'h00A5);
        rd(8'h0B, 8'hA5);
        rd(8'h0C, 8'h00);
        cmt_host_model_inst.xfer(8'h8B, 8'h5A);
        chk({7'h00, cmd_error}, 8'h01);
        rd(8'h0B, 8'hA5);
        @(posedge clk_sys);
        microprocessor_port_mode <= 1'b0;
        cmt_host_model_inst.xfer(8'h0B, 8'h00);
        chk({7'h00, cmd_error}, 8'h01);
        @(posedge clk_sys);
        microprocessor_port_mode <= 1'b1;
        $display("monitor test done");
        cmt_host_model_inst.xfer(8'h91, 8'h00);
        for (int i = 0; i < 10; i++) begin
            ev(sv[i], sx[9 - i]);
        end
        cmt_host_model_inst.xfer(8'h91, 8'h1F);
        ev(11'h7FF, 1'b0);
        $display("interrupt test done");
        conclude;
    end
    initial begin
        #50000;
        error_cnt++;
        conclude;
    end
endmodule : cmt_regs_tb_top
